/* File: voltage_code_pkg.sv */
// shared constants, states and state records for the serial voltage-id receiver
package vid_rx_pkg;

  // ************************************************************
  // widths, field positions and counts
  // ************************************************************
  localparam int          BYTE_W       = 8;
  localparam int          CODE_W       = 7;
  localparam int          CNT_W        = 4;
  localparam int          ADDR_TOP_HI  = 6;
  localparam int          ADDR_TOP_LO  = 4;
  localparam logic [2:0]  ADDR_MATCH   = 3'h6;
  localparam int          SEL_TWO_POS  = 2;
  localparam int          SEL_ONE_POS  = 1;
  localparam int          SEL_NB_POS   = 0;
  localparam int          HINT_POS     = 7;
  localparam logic [3:0]  BYTE_LAST    = 4'h7;
  localparam logic [3:0]  ACK_CLOCKED  = 4'h1;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [6:0]  TARGET_RESET    = 7'h00;
  localparam logic        HINT_N_RESET    = 1'h1;
  localparam logic        OFFSET_RESET    = 1'h0;
  localparam logic        TWO_PHASE_RESET = 1'h1;

  // ************************************************************
  // states and state records
  // ************************************************************
  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_ADDR  = 7'h02,
    S_AACK  = 7'h04,
    S_DATA  = 7'h08,
    S_DACK  = 7'h10,
    S_WSTOP = 7'h20,
    S_IGN   = 7'h40
  } rx_state_t;

  typedef struct packed {
    logic val;
    logic tgl;
  } link_state_t;

  typedef struct packed {
    logic [2:0] tgl_sync;
    logic       val;
    logic       evt;
  } sync_state_t;

  typedef struct packed {
    rx_state_t         state;
    logic [2:0]        scl_sync;
    logic [2:0]        sda_sync;
    logic [1:0]        gnd_sync;
    logic [CNT_W-1:0]  bit_cnt;
    logic [BYTE_W-1:0] shift;
    logic [2:0]        sel;
    logic [BYTE_W-1:0] code;
    logic              sda_out;
    logic              sda_oe_n;
    logic              idle;
    logic              commit;
    logic [CODE_W-1:0] core_one;
    logic [CODE_W-1:0] core_two;
    logic [CODE_W-1:0] nb;
    logic              hint_n;
    logic              offset;
    logic              two_phase;
  } core_state_t;

  localparam core_state_t CORE_RESET = '{
    state:     S_IDLE,
    scl_sync:  3'h7,
    sda_sync:  3'h7,
    gnd_sync:  2'h0,
    bit_cnt:   4'h0,
    shift:     8'h00,
    sel:       3'h0,
    code:      8'h00,
    sda_out:   1'h0,
    sda_oe_n:  1'h1,
    idle:      1'h0,
    commit:    1'h0,
    core_one:  TARGET_RESET,
    core_two:  TARGET_RESET,
    nb:        TARGET_RESET,
    hint_n:    HINT_N_RESET,
    offset:    OFFSET_RESET,
    two_phase: TWO_PHASE_RESET
  };

endpackage

/* File: bit_xfer_if.sv */
// carrier for sampled link bits between the link domain and the core domain
`timescale 1ns/1ps
`default_nettype none
interface bit_xfer_if;
  logic lnk_val;
  logic lnk_tgl;
  logic evt;
  logic evt_val;
  modport sampler  (output lnk_val, output lnk_tgl);
  modport crossing (input lnk_val, input lnk_tgl, output evt, output evt_val);
  modport core     (input evt, input evt_val);
endinterface
`default_nettype wire

/* File: link_bit_sampler.sv */
// link-clock side: samples one data bit per serial clock rising edge
`timescale 1ns/1ps
`default_nettype none
module link_bit_sampler
  import vid_rx_pkg::*;
(
  // link clock and reset
  input  wire logic    link_clk,
  input  wire logic    rst_n,
  // link data pin
  input  wire logic    data_in,
  // toward the core domain
  bit_xfer_if.sampler  xfer
);

  link_state_t st_reg;
  link_state_t st_next;

  // the toggle marks a new bit; the value stays put until the next edge
  always_comb begin
    st_next = st_reg;
    st_next.val = data_in;
    st_next.tgl = ~st_reg.tgl;
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign xfer.lnk_val = st_reg.val;
  assign xfer.lnk_tgl = st_reg.tgl;

endmodule
`default_nettype wire

/* File: bit_event_sync.sv */
// core-clock side of the bit crossing: toggle synchroniser and bit capture
`timescale 1ns/1ps
`default_nettype none
module bit_event_sync
  import vid_rx_pkg::*;
(
  // core clock and reset
  input  wire logic     core_clk,
  input  wire logic     rst_n,
  // bit crossing
  bit_xfer_if.crossing  xfer
);

  sync_state_t st_reg;
  sync_state_t st_next;

  // value is captured only after the toggle has settled two stages,
  // so it has been stable for at least two core cycles by then
  always_comb begin
    st_next          = st_reg;
    st_next.tgl_sync = {st_reg.tgl_sync[1:0], xfer.lnk_tgl};
    st_next.evt      = st_reg.tgl_sync[2] ^ st_reg.tgl_sync[1];
    if (st_reg.tgl_sync[2] ^ st_reg.tgl_sync[1]) begin
      st_next.val = xfer.lnk_val;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign xfer.evt     = st_reg.evt;
  assign xfer.evt_val = st_reg.val;

endmodule
`default_nettype wire

/* File: serial_vid_receiver.sv */
// serial voltage-id receiver: framing, address match, acknowledge, target update
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - receive only; drive data only for acknowledge
// - accept serial clock up to 3.4MHz
// - both lines high means link idle
// - data falls, clock high: start, restart reception
// - data rises, clock high: stop detected
// - command is start, address, data, stop
// - address top bits 110 match, bit 3 ignored
// - ack address only when matched, not programming
// - bits sampled while serial clock high
// - ack both address and data byte
// - hold data low through ack high phase
// - address bit 2 selects core two, ignored combined
// - address bit 1 selects core one or unified
// - address bit 0 selects north-bridge target
// - hint zero: offset off, single phase combined
// - hint one: offset on, two phase combined
// - data bits 6:0 load selected targets
module serial_vid_receiver
  import vid_rx_pkg::*;
(
  // clocks and reset
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic               vid_serial_clock,
  // serial data pin
  input  wire logic               vid_serial_data_in,
  output var  logic               vid_serial_data_out,
  output var  logic               vid_serial_data_oe_n,
  // configuration
  input  wire logic               second_ground_sense,
  input  wire logic               offset_option_en,
  input  wire logic               programming_mode,
  // regulator targets
  output var  logic [CODE_W-1:0]  core_one_target,
  output var  logic [CODE_W-1:0]  core_two_target,
  output var  logic [CODE_W-1:0]  northbridge_target,
  output var  logic               power_save_hint_n,
  output var  logic               offset_active,
  output var  logic               two_phase_active,
  // status
  output var  logic               link_idle,
  output var  logic               update_done
);

  // ************************************************************
  // bit crossing from the serial clock domain
  // ************************************************************
  bit_xfer_if xfer ();

  link_bit_sampler u_sampler (
    .link_clk (vid_serial_clock),
    .rst_n    (rst_n),
    .data_in  (vid_serial_data_in),
    .xfer     (xfer)
  );

  bit_event_sync u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .xfer     (xfer)
  );

  // ************************************************************
  // state and decoded line conditions
  // ************************************************************
  core_state_t st_reg;
  core_state_t st_next;

  logic              scl_s;
  logic              scl_d;
  logic              sda_s;
  logic              sda_d;
  logic              combined;
  logic              start_det;
  logic              stop_det;
  logic              commit_ok;
  logic              addr_hit;
  logic [BYTE_W-1:0] rx_byte;
  logic [6:0]        addr;

  assign scl_s    = st_reg.scl_sync[1];
  assign scl_d    = st_reg.scl_sync[2];
  assign sda_s    = st_reg.sda_sync[1];
  assign sda_d    = st_reg.sda_sync[2];
  // ground sense tied high selects the combined output
  assign combined = st_reg.gnd_sync[1];

  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

  // only a fully acked data byte commits
  assign commit_ok = (st_reg.state == S_WSTOP) & stop_det;

  assign rx_byte = {st_reg.shift[BYTE_W-2:0], xfer.evt_val};
  assign addr    = rx_byte[BYTE_W-1:1];
  // top three bits 110, bit 3 ignored
  assign addr_hit = (addr[ADDR_TOP_HI:ADDR_TOP_LO] == ADDR_MATCH) & ~rx_byte[0];

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb begin
    st_next          = st_reg;
    st_next.scl_sync = {st_reg.scl_sync[1:0], vid_serial_clock};
    st_next.sda_sync = {st_reg.sda_sync[1:0], vid_serial_data_in};
    st_next.gnd_sync = {st_reg.gnd_sync[0], second_ground_sense};
    st_next.commit   = 1'h0;
    st_next.idle     = scl_s & sda_s;

    case (st_reg.state)
      S_ADDR, S_DATA: begin
        if (xfer.evt) begin
          st_next.shift   = rx_byte;
          st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
          if (st_reg.bit_cnt == BYTE_LAST) begin
            st_next.bit_cnt = 4'h0;
            if (st_reg.state == S_DATA) begin
              st_next.code  = rx_byte;
              st_next.state = S_DACK;
            end else if (addr_hit && !programming_mode) begin
              st_next.sel   = addr[SEL_TWO_POS:SEL_NB_POS];
              st_next.state = S_AACK;
            end else begin
              st_next.state = S_IGN;
            end
          end
        end
      end
      S_AACK, S_DACK: begin
        // drive ack in the low phase
        if (st_reg.bit_cnt == 4'h0 && !scl_s) begin
          st_next.sda_oe_n = 1'h0;
        end
        if (xfer.evt) begin
          st_next.bit_cnt = ACK_CLOCKED;
        end
        // release only once the clock is low again
        if (st_reg.bit_cnt == ACK_CLOCKED && !scl_s) begin
          st_next.sda_oe_n = 1'h1;
          st_next.bit_cnt  = 4'h0;
          st_next.state    = (st_reg.state == S_AACK) ? S_DATA : S_WSTOP;
        end
      end
      S_WSTOP: begin
        // the stop's own clock rise is one event; a second means more bits
        if (xfer.evt) begin
          if (st_reg.bit_cnt == 4'h0) begin
            st_next.bit_cnt = ACK_CLOCKED;
          end else begin
            st_next.state = S_IGN;
          end
        end
      end
      S_IDLE, S_IGN: begin
        st_next.bit_cnt = 4'h0;
      end
      default: begin
        st_next.state = S_IDLE;
      end
    endcase

    // start opens, stop closes a command
    if (start_det) begin
      st_next.state    = S_ADDR;
      st_next.bit_cnt  = 4'h0;
      st_next.sda_oe_n = 1'h1;
    end else if (stop_det) begin
      st_next.state    = S_IDLE;
      st_next.bit_cnt  = 4'h0;
      st_next.sda_oe_n = 1'h1;
      if (commit_ok) begin
        st_next.commit = 1'h1;
        st_next.hint_n = st_reg.code[HINT_POS];
        if (st_reg.sel[SEL_ONE_POS]) begin
          st_next.core_one = st_reg.code[CODE_W-1:0];
        end
        if (st_reg.sel[SEL_TWO_POS] && !combined) begin
          st_next.core_two = st_reg.code[CODE_W-1:0];
        end
        if (st_reg.sel[SEL_NB_POS]) begin
          st_next.nb = st_reg.code[CODE_W-1:0];
        end
      end
    end

    // hint low drops offset, and a phase when combined
    st_next.offset    = offset_option_en & st_next.hint_n;
    st_next.two_phase = ~combined | st_next.hint_n;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= CORE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ************************************************************
  // outputs, each straight from the state record
  // ************************************************************
  // pin only ever pulled low
  assign vid_serial_data_out  = st_reg.sda_out;
  assign vid_serial_data_oe_n = st_reg.sda_oe_n;
  assign core_one_target      = st_reg.core_one;
  assign core_two_target      = st_reg.core_two;
  assign northbridge_target   = st_reg.nb;
  assign power_save_hint_n    = st_reg.hint_n;
  assign offset_active        = st_reg.offset;
  assign two_phase_active     = st_reg.two_phase;
  assign link_idle            = st_reg.idle;
  assign update_done          = st_reg.commit;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence addr_last_s;
    st_reg.state == S_ADDR && xfer.evt && st_reg.bit_cnt == BYTE_LAST;
  endsequence

  sequence data_last_s;
    st_reg.state == S_DATA && xfer.evt && st_reg.bit_cnt == BYTE_LAST;
  endsequence

  sequence commit_s;
    commit_ok && !start_det;
  endsequence

  drive_only_ack_a: assert property (
    !vid_serial_data_oe_n |-> (st_reg.state == S_AACK || st_reg.state == S_DACK)
  ) else $error("data line driven outside an acknowledge");

  data_out_low_a: assert property (
    vid_serial_data_out == 1'h0
  ) else $error("data line driven high");

  idle_flag_a: assert property (
    (scl_s && sda_s) ##1 (scl_s && sda_s) |-> link_idle
  ) else $error("idle flag missing with both lines high");

  start_restart_a: assert property (
    start_det |=> st_reg.state == S_ADDR && st_reg.bit_cnt == 4'h0
  ) else $error("start did not restart reception");

  stop_ends_a: assert property (
    (stop_det && !start_det) |=> st_reg.state == S_IDLE && vid_serial_data_oe_n
  ) else $error("stop did not end the command");

  addr_reject_a: assert property (
    (addr_last_s ##0 !addr_hit && !start_det && !stop_det) |=> st_reg.state == S_IGN
  ) else $error("foreign address accepted");

  busy_no_ack_a: assert property (
    (addr_last_s ##0 programming_mode && !start_det && !stop_det) |=> st_reg.state == S_IGN
  ) else $error("address acked while programming");

  addr_ack_a: assert property (
    (addr_last_s ##0 addr_hit && !programming_mode && !start_det && !stop_det)
      |=> st_reg.state == S_AACK && st_reg.sel == $past(addr[SEL_TWO_POS:SEL_NB_POS])
  ) else $error("matched address not acknowledged");

  data_ack_a: assert property (
    (data_last_s ##0 !start_det && !stop_det)
      |=> st_reg.state == S_DACK && st_reg.code == $past(rx_byte)
  ) else $error("data byte not captured");

  ack_hold_a: assert property (
    (!vid_serial_data_oe_n && scl_s && !start_det && !stop_det) |=> !vid_serial_data_oe_n
  ) else $error("acknowledge released during clock high");

  ack_release_a: assert property (
    ($rose(vid_serial_data_oe_n) && $past(!start_det && !stop_det))
      |-> $past(st_reg.bit_cnt) == ACK_CLOCKED && $past(!scl_s)
  ) else $error("acknowledge released before the ninth pulse");

  two_ignored_a: assert property (
    (commit_s ##0 combined) |=> $stable(core_two_target)
  ) else $error("core two target written in combined mode");

  two_update_a: assert property (
    (commit_s ##0 st_reg.sel[SEL_TWO_POS] && !combined)
      |=> core_two_target == $past(st_reg.code[CODE_W-1:0])
  ) else $error("core two target not loaded");

  one_update_a: assert property (
    (commit_s ##0 st_reg.sel[SEL_ONE_POS]) |=> core_one_target == $past(st_reg.code[CODE_W-1:0])
  ) else $error("core one target not loaded");

  nb_update_a: assert property (
    (commit_s ##0 st_reg.sel[SEL_NB_POS]) |=> northbridge_target == $past(st_reg.code[CODE_W-1:0])
  ) else $error("north-bridge target not loaded");

  hint_low_a: assert property (
    !power_save_hint_n |-> !offset_active && (two_phase_active == !$past(combined))
  ) else $error("power-save hint did not drop offset or phase");

  hint_high_a: assert property (
    power_save_hint_n |-> two_phase_active && (offset_active == $past(offset_option_en))
  ) else $error("high-demand hint did not restore offset or phase");

  hint_commit_a: assert property (
    commit_s |=> power_save_hint_n == $past(st_reg.code[HINT_POS])
  ) else $error("power-save hint not committed");

  commit_stop_a: assert property (
    update_done |-> $past(st_reg.state == S_WSTOP && stop_det)
  ) else $error("targets committed without an acked byte and stop");

  abort_keeps_a: assert property (
    !(commit_ok && !start_det)
      |=> $stable(core_one_target) && $stable(core_two_target)
          && $stable(northbridge_target) && $stable(power_save_hint_n)
  ) else $error("targets changed without a commit");

  ignore_quiet_a: assert property (
    st_reg.state == S_IGN |-> vid_serial_data_oe_n
  ) else $error("data line driven while ignoring");

endmodule
`default_nettype wire

/* File: vid_master.sv */
// bus master model for the serial voltage-id link
`timescale 1ns/1ps
`default_nettype none
module vid_master (
  // serial lines, pulled up when released
  output var  logic scl,
  output var  logic sda,
  input  wire logic sda_wire,
  // acknowledge slot and results
  output var  logic in_ack,
  output var  logic ack_a,
  output var  logic ack_d
);
  // ****
  // link timing, 80 ns serial clock, standing high between frames
  // ****
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    in_ack = 1'b0;
    ack_a = 1'b0;
    ack_d = 1'b0;
  end

  // data moves while low, one pulse
  task automatic put_bit(input logic b);
    #20 sda = b;
    #20 scl = 1'b1;
    #40 scl = 1'b0;
  endtask

  // ninth pulse; line released so the pull-up shows
  task automatic ack_bit(output logic a);
    in_ack = 1'b1;
    #20 sda = 1'b1;
    #20 scl = 1'b1;
    #20 a = ~sda_wire;
    #20 scl = 1'b0;
    #40 in_ack = 1'b0;
  endtask

  // start, bytes, stop
  // mode 1 stops mid data byte, mode 2 adds a clock after the data ack
  task automatic frame(input logic [7:0] a, input logic [7:0] d, input int mode);
    #40 sda = 1'b0;
    #40 scl = 1'b0;
    for (int i = 7; i >= 0; i--) put_bit(a[i]);
    ack_bit(ack_a);
    ack_d = 1'b0;
    for (int i = 7; i >= 0; i--) if (mode != 1 || i > 3) put_bit(d[i]);
    if (mode != 1) ack_bit(ack_d);
    if (mode == 2) put_bit(1'b0);
    #20 sda = 1'b0;
    #20 scl = 1'b1;
    #40 sda = 1'b1;
    #200;
  endtask
endmodule
`default_nettype wire

/* File: serial_vid_receiver_tb_top.sv */
// self-checking bench for the serial voltage-id receiver
`timescale 1ns/1ps
`default_nettype none
module serial_vid_receiver_tb_top;
  import vid_rx_pkg::*;
  logic              core_clk, rst_n, scl, sda_m, sda_w;
  logic              in_ack, ack_a, ack_d, gnd, opt, prog;
  logic              d_out, oe_n, idle, done, hint, offs, twop;
  logic [CODE_W-1:0] t_one, t_two, t_nb, e_one, e_two, e_nb;
  logic              e_hint;
  int                errors, checks_done, pulses;

  // device pulls low only through its enable; pull-up otherwise
  assign sda_w = sda_m & (oe_n | d_out);

  vid_master m (.scl(scl), .sda(sda_m), .sda_wire(sda_w), .in_ack(in_ack),
                .ack_a(ack_a), .ack_d(ack_d));

  serial_vid_receiver uut (
    .core_clk(core_clk), .rst_n(rst_n), .vid_serial_clock(scl),
    .vid_serial_data_in(sda_w), .vid_serial_data_out(d_out),
    .vid_serial_data_oe_n(oe_n), .second_ground_sense(gnd),
    .offset_option_en(opt), .programming_mode(prog),
    .core_one_target(t_one), .core_two_target(t_two),
    .northbridge_target(t_nb), .power_save_hint_n(hint),
    .offset_active(offs), .two_phase_active(twop),
    .link_idle(idle), .update_done(done));

  // ****
  // clock, checking and closing
  // ****
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  function automatic logic is_match(input logic [7:0] a, input logic p);
    return a[7:5] == ADDR_MATCH && a[0] == 1'b0 && !p;
  endfunction

  // sampled mid-cycle, where the registered outputs have settled
  always @(negedge core_clk) begin
    if (done === 1'b1) pulses++;
    if (oe_n === 1'b0) check({6'h00, in_ack, d_out}, 8'h02, "drive outside ack");
  end

  // a hang would otherwise hold the run forever
  initial begin
    #200000;
    errors++;
    $display("FAIL %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    logic [7:0] a, d;
    logic       ok, cmt;
    int         mode, p0;
    rst_n = 1'b0;
    gnd = 1'b0;
    opt = 1'b0;
    prog = 1'b0;
    errors = 0;
    checks_done = 0;
    pulses = 0;
    e_one = TARGET_RESET;
    e_two = TARGET_RESET;
    e_nb = TARGET_RESET;
    e_hint = HINT_N_RESET;
    void'($urandom(78275));
    repeat (10) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    check({1'b0, t_one}, {1'b0, TARGET_RESET}, "reset target");
    check({offs, twop, hint, oe_n}, 8'h07, "reset flags");
    check(idle, 1'b1, "idle after reset");
    for (int n = 0; n < 40; n++) begin
      @(posedge core_clk);
      #1;
      gnd = 1'($urandom % 2);
      opt = 1'($urandom % 2);
      prog = ($urandom % 6 == 0);
      a = 8'($urandom);
      d = 8'($urandom);
      mode = $urandom % 4;
      if (mode == 3) mode = 0;
      if ($urandom % 4 != 0) a[7:5] = ADDR_MATCH;
      if ($urandom % 5 != 0) a[0] = 1'b0;
      // first frames walk every target selection
      if (n < 8) begin
        a[7:5] = ADDR_MATCH;
        a[3:1] = n[2:0];
        a[0] = 1'b0;
        prog = 1'b0;
        mode = 0;
      end
      repeat (4) @(posedge core_clk);
      // keep every link edge off the core sampling edge
      #1;
      ok = is_match(a, prog);
      cmt = ok && mode == 0;
      p0 = pulses;
      m.frame(a, d, mode);
      check(ack_a, ok, "address ack");
      check(ack_d, ok && mode != 1, "data ack");
      if (cmt) begin
        if (a[2]) e_one = d[6:0];
        if (a[3] && !gnd) e_two = d[6:0];
        if (a[1]) e_nb = d[6:0];
        e_hint = d[7];
      end
      check(8'(pulses - p0), cmt, "commit pulses");
      check({1'b0, t_one}, {1'b0, e_one}, "core one");
      check({1'b0, t_two}, {1'b0, e_two}, "core two");
      check({1'b0, t_nb}, {1'b0, e_nb}, "northbridge");
      check(hint, e_hint, "hint");
      check(offs, opt & e_hint, "offset");
      check(twop, !gnd | e_hint, "phases");
      check(idle, 1'b1, "idle after stop");
    end
    finish_test();
  end
endmodule
`default_nettype wire
